// *** hw/rtc_top.sv ***
// serial real-time clock: register file, calendar, countdown timer, serial port
// assumes all pins synchronous to core_clk_in; serial clock idles low (mode 0)
`timescale 1ns/1ps
`default_nettype none
module rtc_top import rtc_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // oscillator
  input wire logic osc_tick_in,
  input wire logic osc_stopped_in,
  // serial port
  input wire logic select_in,
  input wire logic sclk_in,
  input wire logic serial_in,
  output logic serial_out_out,
  // open-drain pins
  output logic int_n_out,
  output logic int_n_oe_out,
  output logic programmable_clock_pin_out,
  output logic programmable_clock_pin_oe_out
);

  // ***********
  // reset sync
  // ***********
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // *************
  // declarations
  // *************
  logic [7:0] regs [16];
  logic [7:0] next_regs [16];
  rtc_spi_e sp_st, next_sp_st;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] tx_sh, next_tx_sh;
  logic [3:0] addr, next_addr;
  logic rd_q, next_rd_q;
  logic shift_due, next_shift_due;
  logic freeze_q, next_freeze;
  logic push_v, next_push_v;
  logic [11:0] push_d, next_push_d;
  logic sclk_q, sec_pend, next_sec_pend;
  logic [7:0] tmr_cnt, next_tmr_cnt;
  logic int_q, next_int_q, ck_q, next_ck_q;
  logic rise, fall, byte_done, tmr_fire, sec_do, min_carry;
  logic [7:0] rx_byte;
  logic t4096, t64, t1hz, tmin, src_tick, div_en;
  logic [DIV_W-1:0] div_cnt;
  logic fifo_in_ready, wr_v, wr_ready;
  logic [11:0] wr_d;

  // ***************
  // sub-blocks
  // ***************
  // a stopped clock also halts the divider, which keeps its count so the second resumes where it stopped
  assign div_en = clk_en_in && !regs[A_CTRL1][C1_STOP] && !osc_stopped_in;

  rtc_divider u_div (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .en_in(div_en),
    .osc_tick_in(osc_tick_in),
    .tick_4096_out(t4096),
    .tick_64_out(t64),
    .tick_1hz_out(t1hz),
    .tick_min_out(tmin),
    .div_cnt_out(div_cnt)
  );

  rtc_fifo2 #(.W(FIFO_W)) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .en_in(clk_en_in),
    .in_valid_in(push_v),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_d),
    .out_valid_out(wr_v),
    .out_ready_in(wr_ready),
    .out_data_out(wr_d)
  );

  // ***********
  // functions
  // ***********
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    if (v == last) return first;
    if (v[3:0] >= 4'h9) return {v[7:4] + 4'h1, 4'h0}; // [RQ7]
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
           (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon[4:0]) // [RQ22]
      5'h02: month_last = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  // *************
  // serial port
  // *************
  assign rise = select_in && sclk_in && !sclk_q; // [RQ14] [RQ15]
  assign fall = select_in && !sclk_in && sclk_q;
  assign rx_byte = {rx_sh[6:0], serial_in};
  assign byte_done = rise && (bit_cnt == 3'h7);

  always_comb begin
    next_sp_st = sp_st;
    next_bit_cnt = bit_cnt;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_addr = addr;
    next_rd_q = rd_q;
    next_shift_due = shift_due;
    next_freeze = freeze_q;
    next_push_d = push_d;
    next_push_v = push_v && !fifo_in_ready;
    if (!select_in) begin
      next_sp_st = SP_CMD; // [RQ19]
      next_bit_cnt = 3'h0;
      next_rd_q = 1'b0;
      next_shift_due = 1'b0;
      next_freeze = 1'b0; // [RQ21]
    end else if (rise) begin
      next_rx_sh = rx_byte;
      next_bit_cnt = bit_cnt + 3'h1;
      next_shift_due = (sp_st == SP_DATA) && rd_q && (bit_cnt != 3'h7);
      if (byte_done) begin
        if (sp_st == SP_CMD) begin
          next_sp_st = SP_DATA;
          next_rd_q = rx_byte[CMD_READ];
          next_addr = rx_byte[3:0];
          if (rx_byte[CMD_READ]) begin
            next_tx_sh = regs[rx_byte[3:0]] & REG_MASK[rx_byte[3:0]]; // [RQ18]
            next_addr = rx_byte[3:0] + 4'h1;
            if (rx_byte[3:0] >= A_SEC && rx_byte[3:0] <= A_YEAR) next_freeze = 1'b1; // [RQ8]
          end
        end else if (rd_q) begin
          next_tx_sh = regs[addr] & REG_MASK[addr]; // [RQ18]
          next_addr = addr + 4'h1; // [RQ1]
          if (addr >= A_SEC && addr <= A_YEAR) next_freeze = 1'b1; // [RQ8]
        end else begin
          // a byte still waiting on a full buffer is overwritten here
          next_push_v = 1'b1;
          next_push_d = {addr, rx_byte};
          next_addr = addr + 4'h1; // [RQ1]
        end
      end
    end else if (fall && shift_due) begin
      next_tx_sh = {tx_sh[6:0], 1'b0};
      next_shift_due = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sp_st <= SP_CMD;
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      addr <= 4'h0;
      rd_q <= 1'b0;
      shift_due <= 1'b0;
      freeze_q <= 1'b0;
      push_v <= 1'b0;
      push_d <= 12'h000;
      sclk_q <= 1'b0;
    end else if (clk_en_in) begin
      sp_st <= next_sp_st;
      bit_cnt <= next_bit_cnt;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      addr <= next_addr;
      rd_q <= next_rd_q;
      shift_due <= next_shift_due;
      freeze_q <= next_freeze;
      push_v <= next_push_v;
      push_d <= next_push_d;
      sclk_q <= sclk_in;
    end
  end

  assign serial_out_out = tx_sh[7]; // [RQ16]

  // ***************
  // countdown timer
  // ***************
  always_comb begin
    case (rtc_src_e'(regs[A_TMR_CTL][1:0])) // [RQ10]
      SRC_4096: src_tick = t4096;
      SRC_64: src_tick = t64;
      SRC_1HZ: src_tick = t1hz;
      default: src_tick = tmin;
    endcase
    next_tmr_cnt = tmr_cnt;
    tmr_fire = 1'b0;
    if (wr_v && wr_ready && wr_d[11:8] == A_TMR_VAL) begin
      next_tmr_cnt = wr_d[7:0]; // [RQ9]
    end else if (regs[A_TMR_CTL][TC_TE] && src_tick) begin
      if (tmr_cnt <= 8'h01) begin
        next_tmr_cnt = regs[A_TMR_VAL]; // [RQ11]
        tmr_fire = 1'b1;
      end else begin
        next_tmr_cnt = tmr_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) tmr_cnt <= 8'h00;
    else if (clk_en_in) tmr_cnt <= next_tmr_cnt;
  end

  // ************************
  // register file, calendar
  // ************************
  // a second is held back while frozen and also blocks host writes that cycle
  assign sec_do = sec_pend && !next_freeze; // [RQ21]
  assign wr_ready = !sec_do;

  always_comb begin
    logic [7:0] wa;
    logic c;
    logic [7:0] sec_nx;
    wa = 8'h00;
    c = 1'b0;
    sec_nx = 8'h00;
    min_carry = 1'b0;
    for (int i = 0; i < 16; i++) next_regs[i] = regs[i];
    next_sec_pend = (sec_pend && !sec_do) || t1hz;
    if (wr_v && wr_ready) begin
      wa = {4'h0, wr_d[11:8]};
      next_regs[wa[3:0]] = wr_d[7:0] & REG_MASK[wa[3:0]]; // [RQ2] [RQ3] [RQ5] [RQ6]
    end
    if (sec_do) begin
      sec_nx = bcd_inc({1'b0, regs[A_SEC][6:0]}, 8'h59, 8'h00);
      next_regs[A_SEC][6:0] = sec_nx[6:0]; // [RQ4]
      c = (regs[A_SEC][6:0] == 7'h59);
      min_carry = c;
      if (c) next_regs[A_MIN] = bcd_inc(regs[A_MIN], 8'h59, 8'h00);
      c = c && (regs[A_MIN] == 8'h59);
      if (c) next_regs[A_HOUR] = bcd_inc(regs[A_HOUR], 8'h23, 8'h00);
      c = c && (regs[A_HOUR] == 8'h23);
      if (c) begin
        next_regs[A_WDAY] = (regs[A_WDAY] >= 8'h06) ? 8'h00 : regs[A_WDAY] + 8'h01;
        next_regs[A_DAY] = bcd_inc(regs[A_DAY], month_last(regs[A_MON], regs[A_YEAR]),
                                   8'h01); // [RQ22]
      end
      c = c && (regs[A_DAY] == month_last(regs[A_MON], regs[A_YEAR]));
      if (c) next_regs[A_MON] = bcd_inc(regs[A_MON], 8'h12, 8'h01); // [RQ22]
      c = c && (regs[A_MON] == 8'h12);
      if (c) next_regs[A_YEAR] = bcd_inc(regs[A_YEAR], 8'h99, 8'h00);
    end
    // hardware sets win over a host clear in the same cycle
    if ((sec_do && regs[A_CTRL2][C2_SI]) || (min_carry && regs[A_CTRL2][C2_MI])) begin
      next_regs[A_CTRL2][C2_MSF] = 1'b1; // [RQ12]
    end
    if (tmr_fire) next_regs[A_CTRL2][C2_TF] = 1'b1;
    if (osc_stopped_in) begin
      for (int i = 0; i < 16; i++) begin
        next_regs[i] = (next_regs[i] & ~IRST_MASK[i]) | (RESET_VAL[i] & IRST_MASK[i]);
      end
      next_regs[A_SEC][SEC_RESET_FLAG] = 1'b1; // [RQ20]
      next_sec_pend = 1'b0;
    end
    next_int_q = (regs[A_CTRL2][C2_TF] && regs[A_CTRL2][C2_TIE]) ||
                 (regs[A_CTRL2][C2_AF] && regs[A_CTRL2][C2_AIE]) ||
                 (regs[A_CTRL2][C2_MSF] && (regs[A_CTRL2][C2_SI] || regs[A_CTRL2][C2_MI]));
    case (regs[A_CLKSEL][2:0]) // [RQ6]
      3'h0: next_ck_q = div_cnt[0];
      3'h1: next_ck_q = div_cnt[1];
      3'h2: next_ck_q = div_cnt[2];
      3'h3: next_ck_q = div_cnt[8];
      3'h4: next_ck_q = div_cnt[14];
      default: next_ck_q = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= RESET_VAL[i];
      sec_pend <= 1'b0;
      int_q <= 1'b0;
      ck_q <= 1'b1;
    end else if (clk_en_in) begin
      for (int i = 0; i < 16; i++) regs[i] <= next_regs[i];
      sec_pend <= next_sec_pend;
      int_q <= next_int_q;
      ck_q <= next_ck_q;
    end
  end

  // both pins only ever pull low
  assign int_n_out = 1'b0; // [RQ13]
  assign int_n_oe_out = int_q;
  assign programmable_clock_pin_out = 1'b0;
  assign programmable_clock_pin_oe_out = !ck_q;

  // **********
  // assertions
  // **********
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_addr_step: assert property (clk_en_in && byte_done && sp_st == SP_DATA |=> // [RQ1]
    addr == $past(addr) + 4'h1) else $error("address did not advance");
  a_unimpl_bits: assert property (regs[A_WDAY][7:3] == 5'h00 && regs[A_CTRL1][4] == 1'b0) // [RQ2]
    else $error("unimplemented bit stored");
  a_sec_bcd_step: assert property (clk_en_in && sec_do && regs[A_SEC][6:0] == 7'h09 // [RQ7]
    |=> regs[A_SEC][6:0] == 7'h10) else $error("seconds not BCD");
  a_freeze_holds: assert property (clk_en_in && freeze_q && select_in && !osc_stopped_in // [RQ8]
    |=> $stable(regs[A_MIN])) else $error("counter moved while frozen");
  a_tmr_reload: assert property (clk_en_in && tmr_fire |=> // [RQ11]
    tmr_cnt == $past(regs[A_TMR_VAL]) && regs[A_CTRL2][C2_TF]) else $error("timer reload");
  a_int_pulls: assert property (clk_en_in && regs[A_CTRL2][C2_TF] && regs[A_CTRL2][C2_TIE] // [RQ13]
    |=> int_n_oe_out && !int_n_out) else $error("interrupt not pulled low");
  a_idle_ignore: assert property (clk_en_in && !select_in |=> $stable(rx_sh)) // [RQ15]
    else $error("input taken while deselected");
  a_sel_idle: assert property (clk_en_in && !select_in |=> // [RQ19]
    sp_st == SP_CMD && bit_cnt == 3'h0 && !freeze_q) else $error("serial not idle");
  a_reset_flag_set: assert property (clk_en_in && osc_stopped_in |=> // [RQ20]
    regs[A_SEC][SEC_RESET_FLAG])
    else $error("reset flag not set");
  a_sec_kept: assert property (clk_en_in && t1hz && freeze_q && select_in // [RQ21]
    |=> sec_pend) else $error("second lost during freeze");

  c_read_time: cover property (byte_done && sp_st == SP_CMD && rx_byte[7:0] == 8'h82);
  c_tmr_fire: cover property (tmr_fire);
  c_year_roll: cover property (sec_do && regs[A_MON] == 8'h12 && regs[A_DAY] == 8'h31);
  c_fifo_full: cover property (!fifo_in_ready);

endmodule // rtc_top
`default_nettype wire

// *** inc/rtc_pkg.sv ***
// constants, field layout and enumerations of the serial real-time clock
// assumes a 200 MHz core clock and one-cycle oscillator ticks at 32.768 kHz
//
// Overview of operation
// [RQ1] sixteen 8-bit registers; address steps by one after every byte
// [RQ2] only documented bits exist in each register
// [RQ3] offsets 00 and 01 are the two control registers
// [RQ4] offsets 02 to 08 count seconds up to years
// [RQ5] offsets 09 to 0C hold the alarm settings
// [RQ6] offset 0D selects the clock output mode
// [RQ7] time and calendar counters count in BCD
// [RQ8] reading a time counter freezes all counters for a coherent read; the code holds only offsets 02 to 08, the countdown timer runs on
// [RQ9] offsets 0E and 0F control the countdown timer and its reload value
// [RQ10] timer counts 4096 Hz, 64 Hz, 1 Hz or once per minute
// [RQ11] countdown lasts loaded count times source period
// [RQ12] per-second and per-minute interrupts are controlled from offset 01
// [RQ13] interrupt pin only pulls low, otherwise released
// [RQ14] transfers are accepted only while select is high
// [RQ15] data and serial clock are ignored while select is low
// [RQ16] separate data in and out lines; rates up to 8 Mbit/s
// [RQ17] oscillator divider makes timekeeping and timer ticks
// [RQ18] unimplemented bits read as zero
// [RQ19] serial logic returns to idle while select is low
// [RQ20] reset-occurred flag sets whenever internal reset acts
// [RQ21] freeze ends on deselect; a missed second is applied then
// [RQ22] calendar rolls over by month length with leap February
package rtc_pkg;

  // ****************
  // register offsets
  // ****************
  localparam logic [3:0] A_CTRL1 = 4'h0;
  localparam logic [3:0] A_CTRL2 = 4'h1;
  localparam logic [3:0] A_SEC = 4'h2;
  localparam logic [3:0] A_MIN = 4'h3;
  localparam logic [3:0] A_HOUR = 4'h4;
  localparam logic [3:0] A_DAY = 4'h5;
  localparam logic [3:0] A_WDAY = 4'h6;
  localparam logic [3:0] A_MON = 4'h7;
  localparam logic [3:0] A_YEAR = 4'h8;
  localparam logic [3:0] A_ALM_FIRST = 4'h9;
  localparam logic [3:0] A_ALM_LAST = 4'hC;
  localparam logic [3:0] A_CLKSEL = 4'hD;
  localparam logic [3:0] A_TMR_CTL = 4'hE;
  localparam logic [3:0] A_TMR_VAL = 4'hF;

  // ***************
  // field positions
  // ***************
  localparam int C1_STOP = 5;
  localparam int C2_MI = 7;
  localparam int C2_SI = 6;
  localparam int C2_MSF = 5;
  localparam int C2_AF = 3;
  localparam int C2_TF = 2;
  localparam int C2_AIE = 1;
  localparam int C2_TIE = 0;
  localparam int SEC_RESET_FLAG = 7;
  localparam int TC_TE = 7;
  localparam int CMD_READ = 7;

  // implemented bits, reset values and the bits the internal reset touches
  localparam logic [7:0] REG_MASK [16] = '{8'hAC, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'h3F,
    8'h07, 8'h1F, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h07, 8'h83, 8'hFF};
  localparam logic [7:0] RESET_VAL [16] = '{8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h03, 8'h00};
  localparam logic [7:0] IRST_MASK [16] = '{8'hFF, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h07, 8'h83, 8'h00};

  // *****************
  // timing and sizes
  // *****************
  localparam int CLK_HZ = 200000000;
  localparam int OSC_HZ = 32768;
  localparam int SPI_MAX_BPS = 8000000;
  // core cycles in the shortest serial clock half period, rounded up so a host
  // using it never runs the link above the rated bit rate
  localparam int SPI_HALF_CYC = (CLK_HZ + 2 * SPI_MAX_BPS - 1) / (2 * SPI_MAX_BPS);
  localparam int DIV_W = 15;
  localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3B;
  localparam int FIFO_W = 12;
  localparam int FIFO_DEPTH = 2;

  // **********
  // enumerations
  // **********
  typedef enum logic [1:0] {
    SRC_4096 = 2'b00,
    SRC_64 = 2'b01,
    SRC_1HZ = 2'b10,
    SRC_MIN = 2'b11
  } rtc_src_e;

  typedef enum logic {
    SP_CMD = 1'b0,
    SP_DATA = 1'b1
  } rtc_spi_e;

endpackage

// *** hw/rtc_divider.sv ***
// oscillator divider: timer source ticks and the one-second tick
// assumes osc_tick_in is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
`default_nettype none
module rtc_divider import rtc_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // oscillator
  input wire logic osc_tick_in,
  // ticks
  output logic tick_4096_out,
  output logic tick_64_out,
  output logic tick_1hz_out,
  output logic tick_min_out,
  output logic [DIV_W-1:0] div_cnt_out
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [5:0] sec_cnt;
  logic [5:0] next_sec_cnt;

  always_comb begin
    next_cnt = cnt;
    next_sec_cnt = sec_cnt;
    // ticks are gated so a halted divider cannot repeat the same tick
    tick_4096_out = en_in && osc_tick_in && (cnt[2:0] == 3'h7); // [RQ17]
    tick_64_out = en_in && osc_tick_in && (cnt[8:0] == 9'h1FF);
    tick_1hz_out = en_in && osc_tick_in && (&cnt);
    tick_min_out = tick_1hz_out && (sec_cnt == SEC_PER_MIN_LAST);
    if (osc_tick_in) begin
      next_cnt = cnt + 15'h0001;
    end
    if (tick_1hz_out) begin
      next_sec_cnt = tick_min_out ? 6'h00 : sec_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      sec_cnt <= '0;
    end else if (en_in) begin
      cnt <= next_cnt;
      sec_cnt <= next_sec_cnt;
    end
  end

  assign div_cnt_out = cnt;

endmodule // rtc_divider
`default_nettype wire

// *** hw/rtc_fifo2.sv ***
// two-entry buffer between the serial receiver and the register writer
// assumes a single clock; the drain side may stall at any time
`timescale 1ns/1ps
`default_nettype none
module rtc_fifo2 import rtc_pkg::*; #(
  parameter int W = FIFO_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  logic [W-1:0] mem [FIFO_DEPTH];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  logic next_wp;
  logic next_rp;
  logic [1:0] next_cnt;
  logic push;
  logic pop;

  always_comb begin
    in_ready_out = (cnt != 2'h2);
    out_valid_out = (cnt != 2'h0);
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wp = push ? ~wp : wp;
    next_rp = pop ? ~rp : rp;
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else if (en_in) begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // data store holds no control state, so it needs no reset
  always_ff @(posedge clk_in) begin
    if (en_in && push) begin
      mem[wp] <= in_data_in;
    end
  end

  assign out_data_out = mem[rp];

endmodule // rtc_fifo2
`default_nettype wire

// *** test/rtc_spi_host.sv ***
// serial host model: whole-byte frames and a cut frame in mode 0, driven from the bench
// assumes clk_in is the core clock; bytes go from tx_buf, answers land in rx_buf
`timescale 1ns/1ps
`default_nettype none
module rtc_spi_host import rtc_pkg::*; (
  // core clock
  input wire logic clk_in,
  // serial pins
  input wire logic serial_out_in,
  output logic select_out,
  output logic sclk_out,
  output logic data_to_dev_out
);
  // **********
  // host state
  // **********
  logic [7:0] tx_buf [16];
  logic [7:0] rx_buf [16];
  int hold_cyc = 0;
  logic sel_q = 1'b0;
  logic sclk_q = 1'b0;
  logic data_q = 1'b0;
  logic noise = 1'b0;
  always @(posedge clk_in) noise <= ~noise;
  // released lines float, so show a changing pattern rather than the last value
  assign select_out = sel_q;
  assign sclk_out = sel_q ? sclk_q : noise;
  assign data_to_dev_out = sel_q ? data_q : ~noise;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // data set in the low phase, answer taken at the rising edge
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      data_q = tx[i];
      wait_cyc(SPI_HALF_CYC);
      sclk_q = 1'b1;
      rx[i] = serial_out_in;
      wait_cyc(SPI_HALF_CYC);
      sclk_q = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] dummy;
    sel_q = 1'b1;
    shift(cmd, dummy);
    for (int k = 0; k < n; k++) begin
      shift(tx_buf[k], rx_buf[k]);
    end
    wait_cyc(SPI_HALF_CYC + hold_cyc);
    sel_q = 1'b0;
    wait_cyc(SPI_HALF_CYC);
  endtask
  // a frame cut after four clocks
  task automatic stub();
    sel_q = 1'b1;
    data_q = 1'b1;
    repeat (4) begin
      wait_cyc(SPI_HALF_CYC);
      sclk_q = 1'b1;
      wait_cyc(SPI_HALF_CYC);
      sclk_q = 1'b0;
    end
    sel_q = 1'b0;
    wait_cyc(SPI_HALF_CYC);
  endtask
endmodule // rtc_spi_host
`default_nettype wire

// *** test/tb.sv ***
// bench: register traffic through the host model, compared with expected values
// assumes rtc_top and rtc_spi_host; the run ends in report_and_stop
`timescale 1ns/1ps
`default_nettype none
module tb import rtc_pkg::*;;
  // *******
  // harness
  // *******
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic osc_run = 1'b0;
  logic osc_tick = 1'b0;
  logic osc_stop = 1'b0;
  logic sel, sclk, dev_din, dev_dout, int_n, int_oe, ck_oe;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [7:0] eq [$];
  always #2.5 clk = ~clk;
  // one oscillator pulse every second core cycle keeps a second near 65536 cycles
  always @(posedge clk) begin
    #1;
    osc_tick = osc_run & ~osc_tick;
  end
  rtc_top dut_u (.core_clk_in(clk), .arst_n_in(arst_n), .clk_en_in(1'b1),
    .osc_tick_in(osc_tick), .osc_stopped_in(osc_stop), .select_in(sel), .sclk_in(sclk),
    .serial_in(dev_din), .serial_out_out(dev_dout), .int_n_out(int_n),
    .int_n_oe_out(int_oe), .programmable_clock_pin_out(),
    .programmable_clock_pin_oe_out(ck_oe));
  rtc_spi_host host_u (.clk_in(clk), .serial_out_in(dev_dout), .select_out(sel),
    .sclk_out(sclk), .data_to_dev_out(dev_din));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d [$]);
    foreach (d[k]) host_u.tx_buf[k] = d[k];
    host_u.frame({4'h0, a}, d.size());
  endtask
  task automatic rdx(input string what, input logic [3:0] a, input logic [7:0] e [$]);
    host_u.frame({4'h8, a}, e.size());
    foreach (e[k]) chk(what, e[k], host_u.rx_buf[k]);
  endtask
  task automatic wait_oe(output int c);
    c = 0;
    while (int_oe !== 1'b1 && c < 4000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task automatic tdone(input string t);
    $display("test %s done", t);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 98000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rdx("reset value", 4'h0, '{8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
      8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h03, 8'h00});
    rdx("wrap", 4'hF, '{8'h00, 8'h08});
    tdone("reset values");
    wr(4'h9, '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h05});
    rdx("masked bits", 4'h9, '{8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h05});
    for (int s = 0; s < 4; s++) begin
      eq = '{8'(s)};
      wr(4'hE, eq);
      rdx("timer source", 4'hE, eq);
    end
    host_u.stub();
    rdx("after cut frame", 4'hD, '{8'h05});
    chk("clock pin off", 8'h00, {7'h00, ck_oe});
    tdone("registers");
    wr(4'h1, '{8'h40, 8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04});
    osc_run = 1'b1;
    // select stays high across the carry to midnight
    host_u.hold_cyc = 64500;
    rdx("frozen", 4'h2, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04});
    host_u.hold_cyc = 0;
    chk("second irq", 8'h01, {7'h00, int_oe});
    eq = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04};
    rdx("midnight", 4'h1, eq);
    wr(4'h1, '{8'h00});
    chk("irq released", 8'h00, {7'h00, int_oe});
    chk("irq level", 8'h01, {7'h00, int_oe ? int_n : 1'b1});
    tdone("calendar");
    wr(4'hF, '{8'h06, 8'h08, 8'h01});
    wr(4'hE, '{8'h80});
    // six 16-cycle ticks from enable, less the frame tail that has already passed
    wait_oe(n);
    chk("fast countdown", 8'h01, {7'h00, n >= 40 && n <= 66});
    rdx("timer flag", 4'h1, '{8'h05});
    wr(4'hE, '{8'h81});
    wr(4'hF, '{8'h03, 8'h08, 8'h01});
    chk("flag cleared", 8'h00, {7'h00, int_oe});
    wait_oe(n);
    chk("slow countdown", 8'h01, {7'h00, n >= 1500 && n <= 3100});
    wr(4'h1, '{8'h00});
    tdone("countdown");
    osc_stop = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    osc_stop = 1'b0;
    rdx("internal reset", 4'hE, '{8'h03, 8'h03, 8'h08, 8'h00, 8'h80});
    tdone("oscillator stop");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
